// *** nfc_pkg.sv ***
// package for the nor flash host command sequencer
package nfc_pkg;
	localparam int ADDR_W = 20;
	localparam int DATA_W = 16;
	localparam logic [ADDR_W-1:0] UNLOCK_ADDR1 = 20'h00555;
	localparam logic [ADDR_W-1:0] UNLOCK_ADDR2 = 20'h002aa;
	localparam logic [DATA_W-1:0] UNLOCK_DATA1 = 16'h00aa;
	localparam logic [DATA_W-1:0] UNLOCK_DATA2 = 16'h0055;
	localparam logic [DATA_W-1:0] CMD_RESET = 16'h00f0;
	localparam logic [DATA_W-1:0] CMD_IDENT = 16'h0090;
	localparam logic [DATA_W-1:0] CMD_PROGRAM = 16'h00a0;
	localparam logic [DATA_W-1:0] CMD_ERASE_SETUP = 16'h0080;
	localparam logic [DATA_W-1:0] CMD_CHIP_ERASE = 16'h0010;
	localparam logic [DATA_W-1:0] CMD_SECTOR_ERASE = 16'h0030;
	localparam logic [DATA_W-1:0] CMD_BYPASS = 16'h0020;
	localparam logic [DATA_W-1:0] CMD_BYPASS_EXIT1 = 16'h0090;
	localparam logic [DATA_W-1:0] CMD_BYPASS_EXIT2 = 16'h0000;
	localparam logic [ADDR_W-1:0] ID_MFR_ADDR = 20'h00000;
	localparam logic [ADDR_W-1:0] ID_DEV_ADDR_WORD = 20'h00001;
	localparam logic [ADDR_W-1:0] ID_DEV_ADDR_BYTE = 20'h00002;
	localparam logic [7:0] ID_PROT_WORD = 8'h02;
	localparam logic [7:0] ID_PROT_BYTE = 8'h04;
	// status bit positions on the data bus
	localparam int TOGGLE_BIT = 6;
	localparam int TIMEOUT_BIT = 5;
	// bus phase timing, cycles of the 100 ns clock
	localparam int T_PHASE_NS = 100;
	localparam int CLK_NS = 100;
	localparam logic [1:0] PHASE_CYC = 2'(((T_PHASE_NS + CLK_NS - 1) / CLK_NS));
	localparam int SEQ_MAX = 6;
	localparam logic [2:0] STEP_W = 3'h0;
	typedef enum logic [3:0] {
		NFC_OP_READ = 4'h0, NFC_OP_RESET = 4'h1, NFC_OP_IDENT = 4'h2, NFC_OP_PROGRAM = 4'h3,
		NFC_OP_CHIP_ERASE = 4'h4, NFC_OP_SECTOR_ERASE = 4'h5, NFC_OP_BYPASS_ENTER = 4'h6,
		NFC_OP_BYPASS_PROGRAM = 4'h7, NFC_OP_BYPASS_EXIT = 4'h8, NFC_OP_MORE_SECTOR = 4'h9
	} nfc_op_t;
	typedef struct packed {
		nfc_op_t op;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} nfc_req_t;
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
		logic we;
	} nfc_cycle_t;
	typedef struct packed {
		logic ce_n;
		logic we_n;
		logic oe_n;
		logic dq_oe;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] dq_out;
	} nfc_pins_t;
	typedef enum logic [2:0] {
		NFC_BUS_IDLE = 3'b000, NFC_BUS_SETUP = 3'b001, NFC_BUS_STROBE = 3'b010,
		NFC_BUS_HOLD = 3'b011, NFC_BUS_DONE = 3'b100
	} nfc_bus_st_t;
	typedef struct packed {
		nfc_bus_st_t st;
		logic [1:0] cnt;
		nfc_cycle_t cyc;
		logic [DATA_W-1:0] rdata;
		logic done;
	} nfc_bus_state_t;
endpackage

// *** nfc_bus_cycle.sv ***
// one asynchronous bus cycle (write or read) on the flash pins
`timescale 1ns/10ps
module nfc_bus_cycle (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic start,
	input nfc_pkg::nfc_cycle_t cyc,
	input wire logic [nfc_pkg::DATA_W-1:0] dq_sync,
	output nfc_pkg::nfc_pins_t pins,
	output logic busy,
	output logic done,
	output logic [nfc_pkg::DATA_W-1:0] rdata
);
	nfc_pkg::nfc_bus_state_t s_q, s_d;

	// ----------------------------------------
	// cycle sequencer
	// ----------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.done = 1'b0;
		case (s_q.st)
			nfc_pkg::NFC_BUS_IDLE: begin
				if (start) begin
					s_d.cyc = cyc;
					s_d.st = nfc_pkg::NFC_BUS_SETUP;
					s_d.cnt = nfc_pkg::PHASE_CYC;
				end
			end
			nfc_pkg::NFC_BUS_SETUP: begin
				s_d.cnt = s_q.cnt - 2'h1;
				if (s_q.cnt == 2'h1) begin
					s_d.st = nfc_pkg::NFC_BUS_STROBE;
					s_d.cnt = nfc_pkg::PHASE_CYC + 2'h1;
				end
			end
			nfc_pkg::NFC_BUS_STROBE: begin
				s_d.cnt = s_q.cnt - 2'h1;
				if (s_q.cnt == 2'h1) begin
					s_d.st = nfc_pkg::NFC_BUS_HOLD;
					s_d.cnt = nfc_pkg::PHASE_CYC;
				end
			end
			nfc_pkg::NFC_BUS_HOLD: begin
				s_d.cnt = s_q.cnt - 2'h1;
				if (s_q.cnt == 2'h1) begin
					s_d.st = nfc_pkg::NFC_BUS_IDLE;
					s_d.done = 1'b1;
					// synced data lags the pins by two edges
					s_d.rdata = dq_sync;
				end
			end
			default: begin
				s_d.st = nfc_pkg::NFC_BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------
	// pin drive
	// ----------------------------------------
	// ce held low first, we strobe opens and closes inside it
	always_comb begin
		pins.addr = s_q.cyc.addr;
		pins.dq_out = s_q.cyc.data;
		pins.ce_n = (s_q.st == nfc_pkg::NFC_BUS_IDLE);
		pins.we_n = !(s_q.cyc.we && s_q.st == nfc_pkg::NFC_BUS_STROBE);
		pins.oe_n = !(!s_q.cyc.we && s_q.st == nfc_pkg::NFC_BUS_STROBE);
		pins.dq_oe = s_q.cyc.we && (s_q.st != nfc_pkg::NFC_BUS_IDLE);
	end

	assign busy = (s_q.st != nfc_pkg::NFC_BUS_IDLE);
	assign done = s_q.done;
	assign rdata = s_q.rdata;

	// data stable across we rising edge
	strobe_data_a: assert property (@(posedge clock) disable iff (!rst_b)
		$rose(pins.we_n) |-> $stable(pins.dq_out) && pins.dq_oe && !pins.ce_n) else $error("data moved at we rise");
	strobe_addr_a: assert property (@(posedge clock) disable iff (!rst_b)
		$fell(pins.we_n) |-> $past(!pins.ce_n) && $stable(pins.addr)) else $error("we fell before ce");
	no_bus_conflict_a: assert property (@(posedge clock) disable iff (!rst_b)
		!pins.oe_n |-> !pins.dq_oe && pins.we_n) else $error("read with drive");
endmodule // nfc_bus_cycle

// *** nfc_host.sv ***
// host controller issuing command sequences to the nor flash
`timescale 1ns/10ps
module nfc_host (
	input wire logic clock,
	input wire logic rst_b,
	input nfc_pkg::nfc_req_t req,
	input wire logic req_valid,
	output logic req_ready,
	output logic [nfc_pkg::DATA_W-1:0] rsp_data,
	output logic rsp_valid,
	output logic device_busy,
	output logic seq_failed,
	input wire logic byte_mode,
	input wire logic abort,
	output logic [nfc_pkg::ADDR_W-1:0] flash_addr,
	output logic [nfc_pkg::DATA_W-1:0] flash_dq_out,
	output logic flash_dq_oe,
	input wire logic [nfc_pkg::DATA_W-1:0] flash_dq_in,
	output logic flash_ce_n,
	output logic flash_we_n,
	output logic flash_oe_n,
	output logic flash_width_select_n,
	output logic flash_hw_reset_n,
	input wire logic ready_busy_n
);
	typedef enum logic [2:0] {
		NFC_IDLE = 3'b000, NFC_ISSUE = 3'b001, NFC_WAIT = 3'b010,
		NFC_POLL = 3'b011, NFC_RECOVER = 3'b100, NFC_HWRST = 3'b101
	} nfc_st_t;
	typedef struct packed {
		nfc_st_t st;
		nfc_pkg::nfc_req_t req;
		logic [2:0] idx;
		logic [2:0] len;
		logic toggle_prev;
		logic first_poll;
		logic bypass;
		logic ident;
		logic failed;
		logic rsp_valid;
		logic [nfc_pkg::DATA_W-1:0] rsp;
		logic [1:0] hw_cnt;
	} nfc_host_state_t;

	nfc_host_state_t s_q, s_d;
	logic [nfc_pkg::DATA_W-1:0] dq_meta_q, dq_sync_q;
	logic [1:0] rb_meta_q;
	logic start;
	logic bus_busy;
	logic bus_done;
	logic [nfc_pkg::DATA_W-1:0] bus_rdata;
	nfc_pkg::nfc_cycle_t cyc;
	nfc_pkg::nfc_pins_t pins;
	logic toggle_now;
	logic timeout_now;
	logic rb_sync;

	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			dq_meta_q <= '0;
			dq_sync_q <= '0;
			rb_meta_q <= '1;
		end else begin
			dq_meta_q <= flash_dq_in;
			dq_sync_q <= dq_meta_q;
			rb_meta_q <= {rb_meta_q[0], ready_busy_n};
		end
	end
	assign rb_sync = rb_meta_q[1];

	// ----------------------------------------
	// sequence table
	// ----------------------------------------
	// unlock and command cycles per operation
	function automatic nfc_pkg::nfc_cycle_t seq_cycle(nfc_pkg::nfc_op_t op, logic [2:0] i,
			logic [nfc_pkg::ADDR_W-1:0] a, logic [nfc_pkg::DATA_W-1:0] d);
		nfc_pkg::nfc_cycle_t c;
		c.we = 1'b1;
		c.addr = (i[0] == 1'b0) ? nfc_pkg::UNLOCK_ADDR1 : nfc_pkg::UNLOCK_ADDR2;
		c.data = (i[0] == 1'b0) ? nfc_pkg::UNLOCK_DATA1 : nfc_pkg::UNLOCK_DATA2;
		case (op)
			nfc_pkg::NFC_OP_READ: begin
				c.we = 1'b0;
				c.addr = a;
			end
			nfc_pkg::NFC_OP_RESET: begin
				c.addr = a;
				c.data = nfc_pkg::CMD_RESET;
			end
			nfc_pkg::NFC_OP_BYPASS_PROGRAM: begin
				c.addr = a;
				c.data = (i == 3'h0) ? nfc_pkg::CMD_PROGRAM : d;
			end
			nfc_pkg::NFC_OP_BYPASS_EXIT: begin
				c.addr = a;
				c.data = (i == 3'h0) ? nfc_pkg::CMD_BYPASS_EXIT1 : nfc_pkg::CMD_BYPASS_EXIT2;
			end
			nfc_pkg::NFC_OP_MORE_SECTOR: begin
				c.addr = a;
				c.data = nfc_pkg::CMD_SECTOR_ERASE;
			end
			default: begin
				if (i == 3'h2) begin
					c.addr = nfc_pkg::UNLOCK_ADDR1;
					case (op)
						nfc_pkg::NFC_OP_IDENT: c.data = nfc_pkg::CMD_IDENT;
						nfc_pkg::NFC_OP_PROGRAM: c.data = nfc_pkg::CMD_PROGRAM;
						nfc_pkg::NFC_OP_BYPASS_ENTER: c.data = nfc_pkg::CMD_BYPASS;
						default: c.data = nfc_pkg::CMD_ERASE_SETUP;
					endcase
				end else if (i == 3'h3 && op == nfc_pkg::NFC_OP_PROGRAM) begin
					c.addr = a;
					c.data = d;
				end else if (i == 3'h3) begin
					c.addr = nfc_pkg::UNLOCK_ADDR1;
					c.data = nfc_pkg::UNLOCK_DATA1;
				end else if (i == 3'h4) begin
					c.addr = nfc_pkg::UNLOCK_ADDR2;
					c.data = nfc_pkg::UNLOCK_DATA2;
				end else if (i == 3'h5 && op == nfc_pkg::NFC_OP_SECTOR_ERASE) begin
					c.addr = a;
					c.data = nfc_pkg::CMD_SECTOR_ERASE;
				end else if (i == 3'h5) begin
					c.addr = nfc_pkg::UNLOCK_ADDR1;
					c.data = nfc_pkg::CMD_CHIP_ERASE;
				end
			end
		endcase
		return c;
	endfunction

	function automatic logic [2:0] seq_len(nfc_pkg::nfc_op_t op);
		case (op)
			nfc_pkg::NFC_OP_READ, nfc_pkg::NFC_OP_RESET, nfc_pkg::NFC_OP_MORE_SECTOR: return 3'h1;
			nfc_pkg::NFC_OP_BYPASS_PROGRAM, nfc_pkg::NFC_OP_BYPASS_EXIT: return 3'h2;
			nfc_pkg::NFC_OP_IDENT, nfc_pkg::NFC_OP_BYPASS_ENTER: return 3'h3;
			nfc_pkg::NFC_OP_PROGRAM: return 3'h4;
			default: return 3'h6;
		endcase
	endfunction

	function automatic logic op_busy(nfc_pkg::nfc_op_t op);
		return op == nfc_pkg::NFC_OP_PROGRAM || op == nfc_pkg::NFC_OP_BYPASS_PROGRAM ||
			op == nfc_pkg::NFC_OP_CHIP_ERASE || op == nfc_pkg::NFC_OP_SECTOR_ERASE;
	endfunction

	assign cyc = seq_cycle(s_q.req.op, s_q.idx, s_q.req.addr, s_q.req.data);
	assign toggle_now = bus_rdata[nfc_pkg::TOGGLE_BIT];
	assign timeout_now = bus_rdata[nfc_pkg::TIMEOUT_BIT];

	// ----------------------------------------
	// command sequencer
	// ----------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.rsp_valid = 1'b0;
		start = 1'b0;
		case (s_q.st)
			NFC_IDLE: begin
				if (abort) begin
					s_d.st = NFC_HWRST;
					s_d.hw_cnt = nfc_pkg::PHASE_CYC;
				end else if (req_valid) begin
					s_d.req = req;
					s_d.idx = 3'h0;
					s_d.len = seq_len(req.op);
					s_d.failed = 1'b0;
					s_d.st = NFC_ISSUE;
				end
			end
			NFC_ISSUE: begin
				start = 1'b1;
				s_d.st = NFC_WAIT;
			end
			NFC_WAIT: begin
				if (bus_done) begin
					s_d.idx = s_q.idx + 3'h1;
					if (s_q.idx + 3'h1 != s_q.len) begin
						s_d.st = NFC_ISSUE;
					end else if (s_q.req.op == nfc_pkg::NFC_OP_READ) begin
						s_d.rsp = bus_rdata;
						s_d.rsp_valid = 1'b1;
						s_d.st = NFC_IDLE;
					end else if (op_busy(s_q.req.op)) begin
						s_d.first_poll = 1'b1;
						s_d.req.op = nfc_pkg::NFC_OP_READ;
						s_d.idx = 3'h0;
						s_d.len = 3'h1;
						s_d.st = NFC_POLL;
					end else begin
						s_d.ident = (s_q.req.op == nfc_pkg::NFC_OP_IDENT);
						s_d.bypass = (s_q.req.op == nfc_pkg::NFC_OP_BYPASS_ENTER) ||
							(s_q.bypass && s_q.req.op != nfc_pkg::NFC_OP_BYPASS_EXIT &&
							s_q.req.op != nfc_pkg::NFC_OP_RESET);
						s_d.rsp_valid = 1'b1;
						s_d.st = NFC_IDLE;
					end
				end
			end
			NFC_POLL: begin
				if (!s_q.first_poll && bus_done && toggle_now == s_q.toggle_prev) begin
					s_d.rsp = bus_rdata;
					s_d.rsp_valid = 1'b1;
					s_d.st = NFC_IDLE;
				end else if (bus_done && timeout_now && !s_q.first_poll) begin
					s_d.failed = 1'b1;
					s_d.req.op = nfc_pkg::NFC_OP_RESET;
					s_d.st = NFC_RECOVER;
				end else if (!bus_busy) begin
					start = 1'b1;
				end
				if (bus_done) begin
					s_d.toggle_prev = toggle_now;
					s_d.first_poll = 1'b0;
				end
			end
			NFC_RECOVER: begin
				start = !bus_busy && !bus_done;
				if (bus_done) begin
					s_d.bypass = 1'b0;
					s_d.rsp_valid = 1'b1;
					s_d.st = NFC_IDLE;
				end
			end
			NFC_HWRST: begin
				s_d.hw_cnt = s_q.hw_cnt - 2'h1;
				if (s_q.hw_cnt == 2'h1) begin
					s_d.bypass = 1'b0;
					s_d.ident = 1'b0;
					s_d.st = NFC_IDLE;
				end
			end
			default: begin
				s_d.st = NFC_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	nfc_bus_cycle u_bus (
		.clock(clock),
		.rst_b(rst_b),
		.start(start),
		.cyc(cyc),
		.dq_sync(dq_sync_q),
		.pins(pins),
		.busy(bus_busy),
		.done(bus_done),
		.rdata(bus_rdata)
	);

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign req_ready = (s_q.st == NFC_IDLE) && !abort;
	assign rsp_data = s_q.rsp;
	assign rsp_valid = s_q.rsp_valid;
	assign seq_failed = s_q.failed;
	assign device_busy = !rb_sync || s_q.st == NFC_POLL;
	assign flash_addr = pins.addr;
	assign flash_dq_out = pins.dq_out;
	assign flash_dq_oe = pins.dq_oe;
	assign flash_ce_n = pins.ce_n;
	assign flash_we_n = pins.we_n;
	assign flash_oe_n = pins.oe_n;
	assign flash_width_select_n = !byte_mode;
	assign flash_hw_reset_n = (s_q.st != NFC_HWRST);

	hw_reset_len_a: assert property (@(posedge clock) disable iff (!rst_b)
		$fell(flash_hw_reset_n) |-> !flash_hw_reset_n ##1 flash_hw_reset_n) else $error("reset pulse length");
	no_order_busy_a: assert property (@(posedge clock) disable iff (!rst_b)
		s_q.st == NFC_POLL |-> !req_ready) else $error("ready while busy");
	timeout_reset_a: assert property (@(posedge clock) disable iff (!rst_b)
		s_q.st == NFC_POLL && s_d.st == NFC_RECOVER |=> start ##[1:10] (flash_dq_out == nfc_pkg::CMD_RESET)) else $error("no reset after timeout");
	launch_count_a: assert property (@(posedge clock) disable iff (!rst_b)
		s_q.st == NFC_WAIT && bus_done && s_d.st == NFC_POLL |-> s_q.len == (s_q.req.op == nfc_pkg::NFC_OP_PROGRAM ? 3'h4 :
		s_q.req.op == nfc_pkg::NFC_OP_BYPASS_PROGRAM ? 3'h2 : 3'h6)) else $error("short sequence");
	no_strobe_hwrst_a: assert property (@(posedge clock) disable iff (!rst_b)
		!flash_hw_reset_n |-> flash_ce_n) else $error("bus during reset");
	rsp_idle_a: assert property (@(posedge clock) disable iff (!rst_b)
		rsp_valid |-> s_q.st == NFC_IDLE) else $error("response not idle");
	bypass_exit_a: assert property (@(posedge clock) disable iff (!rst_b)
		s_q.bypass && rsp_valid && $past(s_q.req.op) == nfc_pkg::NFC_OP_BYPASS_EXIT |-> 1'b0) else $error("bypass kept");
	ident_hold_a: assert property (@(posedge clock) disable iff (!rst_b)
		$fell(s_q.ident) |-> $past(s_q.req.op) != nfc_pkg::NFC_OP_READ) else $error("ident dropped");
endmodule // nfc_host

// *** nfc_flash_model.sv ***
// behavioural nor flash device facing the host pins
`timescale 1ns/10ps
module nfc_flash_model #(
	parameter int BUSY_NS = 3000,
	parameter int WIN_NS = 1000,
	// arbitrary identity values
	parameter logic [15:0] MFR_CODE = 16'h005a,
	parameter logic [15:0] DEV_CODE = 16'h00c3,
	parameter logic [4:0] PROT_SECTOR = 5'h1f
) (
	input wire logic [19:0] addr,
	input wire logic [15:0] dq_out,
	input wire logic dq_oe,
	output logic [15:0] dq_in,
	input wire logic ce_n,
	input wire logic we_n,
	input wire logic oe_n,
	input wire logic width_select_n,
	input wire logic hw_reset_n,
	output logic ready_busy_n,
	output int bad_count
);
	// ----
	// command decode
	// ----
	logic [15:0] mem [logic [19:0]];
	logic [19:0] keys [$];
	logic [19:0] wa, pa;
	logic [15:0] wd, pd, rv;
	logic [31:0] sec_mask;
	logic id_mode, byp, busy, win, tog, armed;
	int step, kind;
	wire wr = ~ce_n & ~we_n & oe_n & hw_reset_n;
	wire rd = ~ce_n & ~oe_n & we_n & hw_reset_n;
	initial begin
		{id_mode, byp, busy, win, tog, armed} = '0;
		{step, kind, bad_count} = '0;
		sec_mask = '0;
		rv = '0;
	end
	task automatic fail();
		bad_count++;
		step = 0;
	endtask
	task automatic launch(input int k);
		{pa, pd, kind, busy, win, step} = {wa, wd, k, 1'b1, k == 2, 32'd0};
	endtask
	task automatic decode();
		// writes other than reset counted as faults while busy, more sectors in window
		if (busy) begin
			if (win && kind == 2 && wd == nfc_pkg::CMD_SECTOR_ERASE) sec_mask[wa[19:15]] = 1'b1;
			else if (wd != nfc_pkg::CMD_RESET) bad_count++;
		end else if (id_mode) begin
			if (wd == nfc_pkg::CMD_RESET) id_mode = 1'b0;
			else bad_count++;
		end else if (wd == nfc_pkg::CMD_RESET && step != 3) step = 0;
		else case (step)
			0: if (byp && wd == nfc_pkg::CMD_PROGRAM) step = 3;
				else if (byp && wd == nfc_pkg::CMD_BYPASS_EXIT1) step = 9;
				else if (!byp && wa == nfc_pkg::UNLOCK_ADDR1 && wd == nfc_pkg::UNLOCK_DATA1) step = 1;
				else fail();
			4: if (wa == nfc_pkg::UNLOCK_ADDR1 && wd == nfc_pkg::UNLOCK_DATA1) step = 5; else fail();
			1, 5: if (wa == nfc_pkg::UNLOCK_ADDR2 && wd == nfc_pkg::UNLOCK_DATA2) step++; else fail();
			2: begin
				step = 0;
				if (wa != nfc_pkg::UNLOCK_ADDR1) fail();
				else if (wd == nfc_pkg::CMD_IDENT) id_mode = 1'b1;
				else if (wd == nfc_pkg::CMD_PROGRAM) step = 3;
				else if (wd == nfc_pkg::CMD_ERASE_SETUP) step = 4;
				else if (wd == nfc_pkg::CMD_BYPASS) byp = 1'b1;
				else fail();
			end
			3: launch(0);
			6: if (wa == nfc_pkg::UNLOCK_ADDR1 && wd == nfc_pkg::CMD_CHIP_ERASE) launch(1);
				else if (wd == nfc_pkg::CMD_SECTOR_ERASE) begin
					sec_mask[wa[19:15]] = 1'b1;
					launch(2);
				end else fail();
			9: if (wd == nfc_pkg::CMD_BYPASS_EXIT2) {byp, step} = '0; else fail();
			default: fail();
		endcase
	endtask
	always @(posedge wr) if (wr === 1'b1) {wa, armed} = {addr, 1'b1};
	always @(negedge wr) if (armed) begin
		{wd, armed} = {dq_out, 1'b0};
		if (!dq_oe) bad_count++;
		decode();
	end
	always @(posedge rd) if (rd === 1'b1) begin
		if (busy) begin
			tog = ~tog;
			rv = {8'h00, (kind == 0) ? ~pd[7] : 1'b0, tog, 2'b00, ~win, 3'b000};
		end else if (id_mode) begin
			if (addr[7:0] == 8'h00) rv = MFR_CODE;
			else if (addr[7:0] == (width_select_n ? 8'h01 : 8'h02)) rv = DEV_CODE;
			else if (addr[7:0] == (width_select_n ? 8'h02 : 8'h04)) rv = {15'h0, addr[19:15] == PROT_SECTOR};
			else rv = 16'h0000;
		end else rv = mem.exists(addr) ? mem[addr] : 16'hffff;
	end
	// released bus shows inverse of last value
	assign dq_in = rd ? rv : ~rv;
	assign ready_busy_n = ~busy;
	always @(negedge hw_reset_n) {step, id_mode, byp} = '0;
	always begin
		wait (busy);
		fork
			begin
				if (kind == 2) #(WIN_NS);
				win = 1'b0;
				#(BUSY_NS);
			end
			@(negedge hw_reset_n);
		join_any
		disable fork;
		// program clears bits, erase self contained
		if (hw_reset_n && kind == 0) mem[pa] = (mem.exists(pa) ? mem[pa] : 16'hffff) & pd;
		else if (hw_reset_n) begin
			keys.delete();
			foreach (mem[k]) if (kind == 1 || sec_mask[k[19:15]]) keys.push_back(k);
			foreach (keys[i]) mem.delete(keys[i]);
		end
		{busy, win, sec_mask} = '0;
	end
endmodule // nfc_flash_model

// *** nfc_host_tb.sv ***
// self-checking bench for the nor flash host sequencer
`timescale 1ns/10ps
module nfc_host_tb;
	localparam int LIM = 3000;
	localparam logic [15:0] MFR = 16'h005a;
	localparam logic [15:0] DEV = 16'h00c3;
	logic clock, rst_b, req_valid, byte_mode, abort, req_ready, rsp_valid, device_busy, seq_failed;
	logic dq_oe, ce_n, we_n, oe_n, width_select_n, hw_reset_n, ready_busy_n;
	nfc_pkg::nfc_req_t req;
	logic [15:0] rsp_data, dq_out, dq_in;
	logic [19:0] addr;
	int fail_count, cmp_count, bad_count;
	nfc_host dut (.clock(clock), .rst_b(rst_b), .req(req), .req_valid(req_valid), .req_ready(req_ready),
		.rsp_data(rsp_data), .rsp_valid(rsp_valid), .device_busy(device_busy), .seq_failed(seq_failed),
		.byte_mode(byte_mode), .abort(abort), .flash_addr(addr), .flash_dq_out(dq_out), .flash_dq_oe(dq_oe),
		.flash_dq_in(dq_in), .flash_ce_n(ce_n), .flash_we_n(we_n), .flash_oe_n(oe_n),
		.flash_width_select_n(width_select_n), .flash_hw_reset_n(hw_reset_n), .ready_busy_n(ready_busy_n));
	nfc_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) flash (.addr(addr), .dq_out(dq_out), .dq_oe(dq_oe),
		.dq_in(dq_in), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .width_select_n(width_select_n),
		.hw_reset_n(hw_reset_n), .ready_busy_n(ready_busy_n), .bad_count(bad_count));
	// ----
	// shared tasks
	// ----
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	task automatic finish_test();
		if (fail_count == 0 && cmp_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			$display("[ERR] %s expected %h seen %h", what, exp, got);
			fail_count++;
		end
	endtask
	task automatic op(input nfc_pkg::nfc_op_t o, input logic [19:0] a, input logic [15:0] d);
		int n;
		logic rdy;
		n = 0;
		req <= '{op: o, addr: a, data: d};
		req_valid <= 1'b1;
		do begin
			@(negedge clock);
			rdy = req_ready;
			@(posedge clock);
			n++;
		end while (rdy !== 1'b1 && n < LIM);
		req_valid <= 1'b0;
		do begin
			@(negedge clock);
			n++;
		end while (rsp_valid !== 1'b1 && n < LIM);
		@(posedge clock);
		if (n >= LIM) begin
			check("order timeout", 16'h0001, 16'h0000);
			finish_test();
		end
	endtask
	task automatic rd_chk(input string what, input logic [19:0] a, input logic [15:0] exp);
		op(nfc_pkg::NFC_OP_READ, a, 16'h0000);
		check(what, exp, rsp_data);
	endtask
	// ----
	// scenarios
	// ----
	task automatic t_reset();
		check("idle pins", 16'h001f, {10'h0, device_busy, ce_n, we_n, oe_n, hw_reset_n, req_ready});
		rd_chk("blank read", 20'h00010, 16'hffff);
	endtask
	task automatic t_program();
		op(nfc_pkg::NFC_OP_PROGRAM, 20'h00123, 16'h1234);
		rd_chk("program", 20'h00123, 16'h1234);
		op(nfc_pkg::NFC_OP_PROGRAM, 20'h00123, 16'h00f3);
		rd_chk("zeros kept", 20'h00123, 16'h0030);
	endtask
	task automatic t_ident(input logic bm);
		byte_mode <= bm;
		@(posedge clock);
		op(nfc_pkg::NFC_OP_IDENT, 20'h00000, 16'h0000);
		rd_chk("maker", 20'h00000, MFR);
		rd_chk("device", bm ? 20'h00002 : 20'h00001, DEV);
		rd_chk("locked", {5'h1f, 7'h0, bm ? 8'h04 : 8'h02}, 16'h0001);
		rd_chk("unlocked", {5'h01, 7'h0, bm ? 8'h04 : 8'h02}, 16'h0000);
		op(nfc_pkg::NFC_OP_RESET, 20'habcde, 16'h0000);
		rd_chk("array again", 20'h00123, 16'h0030);
		byte_mode <= 1'b0;
		@(posedge clock);
	endtask
	task automatic t_bypass();
		op(nfc_pkg::NFC_OP_BYPASS_ENTER, 20'h00000, 16'h0000);
		op(nfc_pkg::NFC_OP_BYPASS_PROGRAM, 20'h08000, 16'h00ff);
		op(nfc_pkg::NFC_OP_BYPASS_PROGRAM, 20'h08001, 16'h0f0f);
		op(nfc_pkg::NFC_OP_BYPASS_EXIT, 20'h00000, 16'h0000);
		rd_chk("bypass word 0", 20'h08000, 16'h00ff);
		rd_chk("bypass word 1", 20'h08001, 16'h0f0f);
	endtask
	task automatic t_erase();
		op(nfc_pkg::NFC_OP_SECTOR_ERASE, 20'h08000, 16'h0000);
		rd_chk("sector erased", 20'h08001, 16'hffff);
		rd_chk("sector kept", 20'h00123, 16'h0030);
		op(nfc_pkg::NFC_OP_CHIP_ERASE, 20'h00000, 16'h0000);
		rd_chk("chip erased", 20'h00123, 16'hffff);
	endtask
	task automatic t_abort();
		int n;
		n = 0;
		op(nfc_pkg::NFC_OP_IDENT, 20'h00000, 16'h0000);
		abort <= 1'b1;
		do begin
			@(negedge clock);
			n++;
		end while (hw_reset_n !== 1'b0 && n < LIM);
		@(posedge clock);
		abort <= 1'b0;
		do begin
			@(negedge clock);
			n++;
		end while (hw_reset_n !== 1'b1 && n < LIM);
		@(posedge clock);
		check("reset pulse", 16'h0001, {15'h0, n < LIM});
		rd_chk("after pin reset", 20'h00000, 16'hffff);
	endtask
	initial begin
		rst_b = 1'b0;
		req_valid = 1'b0;
		byte_mode = 1'b0;
		abort = 1'b0;
		req = '0;
		fail_count = 0;
		cmp_count = 0;
		repeat (8) @(posedge clock);
		rst_b <= 1'b1;
		@(posedge clock);
		t_reset();
		t_program();
		t_ident(1'b0);
		t_ident(1'b1);
		t_bypass();
		t_erase();
		t_abort();
		check("device faults", 16'h0000, bad_count[15:0]);
		check("end status", 16'h0001, {14'h0, device_busy, ready_busy_n});
		check("failed flag", 16'h0000, {15'h0, seq_failed});
		finish_test();
	end
endmodule // nfc_host_tb
